// >>> rtl/pbis_pkg.sv
// Package: offsets, field layouts and reset values of the port base/status slice
package pbis_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] PBIS_PORT_BASE     = 12'h100;
  localparam logic [11:0] PBIS_PORT_STRIDE   = 12'h080;
  localparam logic [6:0]  PBIS_OFS_CLB_LO    = 7'h00;
  localparam logic [6:0]  PBIS_OFS_CLB_HI    = 7'h04;
  localparam logic [6:0]  PBIS_OFS_RXB_LO    = 7'h08;
  localparam logic [6:0]  PBIS_OFS_RXB_HI    = 7'h0C;
  localparam logic [6:0]  PBIS_OFS_STATUS    = 7'h10;

  // ----------------------------------------------------------------------
  // Field layouts
  // ----------------------------------------------------------------------
  localparam int          PBIS_CLB_LSB       = 10;
  localparam int          PBIS_RXB_LSB       = 8;
  localparam int          PBIS_RXB_FBS_LSB   = 12;
  localparam int          PBIS_ST_LSB        = 26;
  localparam int          PBIS_ST_W          = 6;
  localparam int          PBIS_EV_COLD       = 5;
  localparam int          PBIS_EV_TFERR      = 4;
  localparam int          PBIS_EV_HBFATAL    = 3;
  localparam int          PBIS_EV_HBDATA     = 2;
  localparam int          PBIS_EV_LFATAL     = 1;
  localparam int          PBIS_EV_LNONFATAL  = 0;
  localparam int          PBIS_TF_ERR_BIT    = 0;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [31:0] PBIS_RST_WORD      = 32'h0000_0000;
  localparam logic [5:0]  PBIS_RST_STATUS    = 6'h00;

endpackage : pbis_pkg

// >>> rtl/pbis_port_regs.sv
// Port command-list/receive-area base registers and upper event status bits
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none

module pbis_port_regs
  import pbis_pkg::*;
#(
  parameter int          PORT_NUM  = 0,
  parameter bit          ADDR64    = 1'b1
) (
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        cold_presence_capable,
  input  wire logic        cold_presence_event,
  input  wire logic        tf_status_update,
  input  wire logic [7:0]  tf_status,
  input  wire logic        host_bus_fatal_event,
  input  wire logic        host_bus_data_event,
  input  wire logic        link_fatal_event,
  input  wire logic        link_nonfatal_event,
  input  wire logic        fbs_enable,
  output logic      [63:0] cmd_list_base,
  output logic      [63:0] rx_area_base,
  output logic             rx_area_misaligned,
  output logic      [5:0]  event_flags
);

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  localparam logic [11:0] PORT_OFS = PBIS_PORT_BASE + PBIS_PORT_STRIDE * 12'(PORT_NUM);
  localparam int          PORT_LSB = $clog2(PBIS_PORT_STRIDE);

  wire logic [11:0] rel_addr = reg_addr - PORT_OFS;
  wire logic        in_port  = (reg_addr[11:PORT_LSB] == PORT_OFS[11:PORT_LSB]);
  wire logic [6:0]  ofs      = rel_addr[PORT_LSB-1:0];
  wire logic        sel_clbl = in_port && (ofs == PBIS_OFS_CLB_LO);
  wire logic        sel_clbh = in_port && (ofs == PBIS_OFS_CLB_HI);
  wire logic        sel_rxbl = in_port && (ofs == PBIS_OFS_RXB_LO);
  wire logic        sel_rxbh = in_port && (ofs == PBIS_OFS_RXB_HI);
  wire logic        sel_st   = in_port && (ofs == PBIS_OFS_STATUS);

  // ----------------------------------------------------------------------
  // Base address registers
  // ----------------------------------------------------------------------
  logic [31:PBIS_CLB_LSB] cmd_list_base_field_r;
  logic [31:0]            cmd_list_base_upper_field_r;
  logic [31:PBIS_RXB_LSB] rx_area_base_field_r;
  logic [31:0]            rx_area_base_upper_field_r;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cmd_list_base_field_r <= PBIS_RST_WORD[31:PBIS_CLB_LSB];
      rx_area_base_field_r  <= PBIS_RST_WORD[31:PBIS_RXB_LSB];
    end else begin
      if (reg_wr && sel_clbl) begin
        cmd_list_base_field_r <= reg_wdata[31:PBIS_CLB_LSB];
      end
      if (reg_wr && sel_rxbl) begin
        rx_area_base_field_r <= reg_wdata[31:PBIS_RXB_LSB];
      end
    end
  end

  generate
    if (ADDR64) begin : g_upper
      always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
          cmd_list_base_upper_field_r <= PBIS_RST_WORD;
          rx_area_base_upper_field_r  <= PBIS_RST_WORD;
        end else begin
          if (reg_wr && sel_clbh) begin
            cmd_list_base_upper_field_r <= reg_wdata;
          end
          if (reg_wr && sel_rxbh) begin
            rx_area_base_upper_field_r <= reg_wdata;
          end
        end
      end
    end else begin : g_no_upper
      // Upper words read-only zero without 64-bit support
      assign cmd_list_base_upper_field_r = PBIS_RST_WORD;
      assign rx_area_base_upper_field_r  = PBIS_RST_WORD;
    end
  endgenerate

  wire logic [31:0] clb_lo_word = {cmd_list_base_field_r, {PBIS_CLB_LSB{1'b0}}};
  wire logic [31:0] rxb_lo_word = {rx_area_base_field_r, {PBIS_RXB_LSB{1'b0}}};

  // Fetch logic sees the full 1 KiB aligned base
  assign cmd_list_base = {cmd_list_base_upper_field_r, clb_lo_word};
  assign rx_area_base  = {rx_area_base_upper_field_r, rxb_lo_word};
  // Alignment is software's job; flagged so frame logic can refuse it
  assign rx_area_misaligned = fbs_enable &&
                              (rx_area_base_field_r[PBIS_RXB_FBS_LSB-1:PBIS_RXB_LSB] != '0);

  // ----------------------------------------------------------------------
  // Event status bits
  // ----------------------------------------------------------------------
  logic [PBIS_ST_W-1:0] status_r;
  logic [PBIS_ST_W-1:0] status_nxt;
  logic [PBIS_ST_W-1:0] ev_set;

  assign ev_set[PBIS_EV_COLD]      = cold_presence_event && cold_presence_capable;
  assign ev_set[PBIS_EV_TFERR]     = tf_status_update && tf_status[PBIS_TF_ERR_BIT];
  assign ev_set[PBIS_EV_HBFATAL]   = host_bus_fatal_event;
  assign ev_set[PBIS_EV_HBDATA]    = host_bus_data_event;
  assign ev_set[PBIS_EV_LFATAL]    = link_fatal_event;
  assign ev_set[PBIS_EV_LNONFATAL] = link_nonfatal_event;

  wire logic [PBIS_ST_W-1:0] st_clr = (reg_wr && sel_st) ?
                                      reg_wdata[PBIS_ST_LSB +: PBIS_ST_W] : '0;

  genvar gi;
  generate
    for (gi = 0; gi < PBIS_ST_W; gi++) begin : g_st
      // Set beats clear so a same-cycle event is never lost
      assign status_nxt[gi] = ev_set[gi] | (status_r[gi] & ~st_clr[gi]);
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      status_r <= PBIS_RST_STATUS;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign event_flags = status_r;

  // ----------------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------------
  logic [31:0] rdata_r;

  wire logic [31:0] st_word = {status_r, {PBIS_ST_LSB{1'b0}}};
  wire logic [31:0] rd_mux  = sel_clbl ? clb_lo_word :
                              sel_clbh ? cmd_list_base_upper_field_r :
                              sel_rxbl ? rxb_lo_word :
                              sel_rxbh ? rx_area_base_upper_field_r :
                              sel_st   ? st_word : PBIS_RST_WORD;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rdata_r <= PBIS_RST_WORD;
    end else begin
      rdata_r <= reg_rd ? rd_mux : PBIS_RST_WORD;
    end
  end

  assign reg_rdata = rdata_r;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_wr_clbl;
    reg_wr && sel_clbl;
  endsequence

  sequence s_wr_clbh;
    reg_wr && sel_clbh;
  endsequence

  sequence s_wr_rxbl;
    reg_wr && sel_rxbl;
  endsequence

  sequence s_wr_rxbh;
    reg_wr && sel_rxbh;
  endsequence

  sequence s_wr_st;
    reg_wr && sel_st;
  endsequence

  sequence s_rd_clbl;
    reg_rd && sel_clbl;
  endsequence

  sequence s_rd_clbh;
    reg_rd && sel_clbh;
  endsequence

  sequence s_rd_rxbl;
    reg_rd && sel_rxbl;
  endsequence

  sequence s_rd_rxbh;
    reg_rd && sel_rxbh;
  endsequence

  clb_low_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_wr_clbl |=> (cmd_list_base[31:0] == {$past(reg_wdata[31:PBIS_CLB_LSB]), {PBIS_CLB_LSB{1'b0}}}))
    else $error("command list base low not stored as aligned word");

  clb_align_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cmd_list_base[PBIS_CLB_LSB-1:0] == '0)
    else $error("command list base not 1 KiB aligned");

  clb_high_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_wr && sel_clbh |=> cmd_list_base[63:32] == (ADDR64 ? $past(reg_wdata) : 32'h0))
    else $error("command list base upper word wrong");

  rxb_low_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_wr_rxbl |=> rx_area_base[31:0] == {$past(reg_wdata[31:PBIS_RXB_LSB]), {PBIS_RXB_LSB{1'b0}}})
    else $error("receive area base low wrong");

  rxb_fbs_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rx_area_misaligned == (fbs_enable && rx_area_base[PBIS_RXB_FBS_LSB-1:PBIS_RXB_LSB] != '0))
    else $error("4 KiB alignment check wrong");

  rxb_high_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_wr && sel_rxbh |=> rx_area_base[63:32] == (ADDR64 ? $past(reg_wdata) : 32'h0))
    else $error("receive area base upper word wrong");

  cold_set_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    cold_presence_event && cold_presence_capable |=> event_flags[PBIS_EV_COLD])
    else $error("cold presence flag not set");

  cold_gate_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !cold_presence_capable && !event_flags[PBIS_EV_COLD] |=> !event_flags[PBIS_EV_COLD])
    else $error("cold presence flag set while not capable");

  tf_err_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    tf_status_update && tf_status[PBIS_TF_ERR_BIT] |=> event_flags[PBIS_EV_TFERR])
    else $error("task file error flag not set");

  hb_fatal_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    host_bus_fatal_event |=> event_flags[PBIS_EV_HBFATAL])
    else $error("host bus fatal flag not set");

  hb_data_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    host_bus_data_event |=> event_flags[PBIS_EV_HBDATA])
    else $error("host bus data flag not set");

  link_fatal_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    link_fatal_event |=> event_flags[PBIS_EV_LFATAL])
    else $error("link fatal flag not set");

  link_nonfatal_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    link_nonfatal_event |=> event_flags[PBIS_EV_LNONFATAL])
    else $error("link non-fatal flag not set");

  w1c_clear_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_wr && sel_st |=> event_flags == ($past(ev_set) |
      ($past(event_flags) & ~$past(reg_wdata[PBIS_ST_LSB +: PBIS_ST_W]))))
    else $error("write-one-to-clear misbehaved");

  port_map_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_rd && (reg_addr == PORT_OFS + 12'(PBIS_OFS_STATUS)) |=>
      reg_rdata == {$past(event_flags), {PBIS_ST_LSB{1'b0}}})
    else $error("status not found at port offset");

  clb_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(reg_wr && sel_clbl) |=> cmd_list_base[31:0] == $past(cmd_list_base[31:0]))
    else $error("command list base low changed without a write");

  clbh_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(reg_wr && sel_clbh) |=> cmd_list_base[63:32] == $past(cmd_list_base[63:32]))
    else $error("command list base upper changed without a write");

  rxb_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(reg_wr && sel_rxbl) |=> rx_area_base[31:0] == $past(rx_area_base[31:0]))
    else $error("receive area base low changed without a write");

  rxbh_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(reg_wr && sel_rxbh) |=> rx_area_base[63:32] == $past(rx_area_base[63:32]))
    else $error("receive area base upper changed without a write");

  rxb_align_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    rx_area_base[PBIS_RXB_LSB-1:0] == '0)
    else $error("receive area base not 256-byte aligned");

  clb_rd_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_rd_clbl |=> reg_rdata == $past(cmd_list_base[31:0]))
    else $error("command list base low read wrong");

  clbh_rd_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_rd_clbh |=> reg_rdata == $past(cmd_list_base[63:32]))
    else $error("command list base upper read wrong");

  rxb_rd_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_rd_rxbl |=> reg_rdata == $past(rx_area_base[31:0]))
    else $error("receive area base low read wrong");

  rxbh_rd_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_rd_rxbh |=> reg_rdata == $past(rx_area_base[63:32]))
    else $error("receive area base upper read wrong");

  rd_idle_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !reg_rd |=> reg_rdata == '0)
    else $error("read data not zero outside read slot");

  rd_foreign_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    reg_rd && ({1'b0, reg_addr} < {1'b0, PORT_OFS} ||
      {1'b0, reg_addr} >= {1'b0, PORT_OFS} + {1'b0, PBIS_PORT_STRIDE}) |=> reg_rdata == '0)
    else $error("foreign address answered");

  st_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(reg_wr && sel_st) |=> ($past(event_flags) & ~event_flags) == '0)
    else $error("status flag dropped without a write");

  set_wins_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_wr_st ##0 (ev_set != '0) |=> (event_flags & $past(ev_set)) == $past(ev_set))
    else $error("clear beat a same-cycle event");

  w1c_keep_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    s_wr_st |=> ($past(event_flags) & ~$past(reg_wdata[PBIS_ST_LSB +: PBIS_ST_W]) &
      ~event_flags) == '0)
    else $error("written zero cleared a status flag");

  tf_quiet_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !(tf_status_update && tf_status[PBIS_TF_ERR_BIT]) && !event_flags[PBIS_EV_TFERR] |=>
      !event_flags[PBIS_EV_TFERR])
    else $error("task file error flag set without error");

  hb_quiet_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !host_bus_fatal_event && !event_flags[PBIS_EV_HBFATAL] |=> !event_flags[PBIS_EV_HBFATAL])
    else $error("host bus fatal flag set without event");

  link_quiet_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !link_fatal_event && !event_flags[PBIS_EV_LFATAL] |=> !event_flags[PBIS_EV_LFATAL])
    else $error("link fatal flag set without event");

endmodule : pbis_port_regs

`default_nettype wire

// >>> test/pbis_event_src.sv
// Event source model for the engines that raise the port's error and change events
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Event pulse generator
// ----------------------------------------------------------------------
module pbis_event_src (
  input  wire logic       clk_sys,
  output wire logic       cold_presence_capable,
  output wire logic       cold_presence_event,
  output wire logic       tf_status_update,
  output wire logic [7:0] tf_status,
  output wire logic       host_bus_fatal_event,
  output wire logic       host_bus_data_event,
  output wire logic       link_fatal_event,
  output wire logic       link_nonfatal_event
);
  logic [5:0] ev_r  = 6'h00;
  logic       cap_r = 1'b0;
  logic [7:0] st_r  = 8'h00;

  assign cold_presence_capable = cap_r;
  assign tf_status             = st_r;
  assign {cold_presence_event, tf_status_update, host_bus_fatal_event,
          host_bus_data_event, link_fatal_event, link_nonfatal_event} = ev_r;

  // One-cycle pulses; mask bit 5 down to 0 follow status bits 31 down to 26
  task automatic fire(input logic [5:0] m, input logic c, input logic [7:0] st);
    @(posedge clk_sys);
    cap_r <= c;
    st_r  <= st;
    ev_r  <= m;
    @(posedge clk_sys);
    ev_r  <= 6'h00;
    // Stale status byte is not held past its strobe
    st_r  <= ~st;
  endtask : fire
endmodule : pbis_event_src
`default_nettype wire

// >>> test/tb_port_base_and_irq_status.sv
// Self-checking bench for the port base and event status registers
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Bench top
// ----------------------------------------------------------------------
module tb_port_base_and_irq_status;
  import pbis_pkg::*;
  // Port 1 so that a port-0 address is a foreign one
  localparam logic [11:0] BASE = PBIS_PORT_BASE + PBIS_PORT_STRIDE;
  logic        clk_sys    = 1'b0;
  logic        arst_n     = 1'b0;
  logic [11:0] reg_addr   = 12'h000;
  logic [31:0] reg_wdata  = 32'h0000_0000;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic        fbs_enable = 1'b0;
  wire logic   cold_presence_capable, cold_presence_event, tf_status_update;
  wire logic   host_bus_fatal_event, host_bus_data_event;
  wire logic   link_fatal_event, link_nonfatal_event;
  wire logic [7:0] tf_status;
  logic [31:0] reg_rdata;
  logic [63:0] cmd_list_base, rx_area_base;
  logic        rx_area_misaligned;
  logic [5:0]  event_flags;
  int          err_total = 0;
  int          cmp_count = 0;

  always #2.5 clk_sys = ~clk_sys;

  pbis_port_regs #(.PORT_NUM(1), .ADDR64(1'b1)) pbis_port_regs_i (.clk_sys, .arst_n,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cold_presence_capable,
    .cold_presence_event, .tf_status_update, .tf_status, .host_bus_fatal_event,
    .host_bus_data_event, .link_fatal_event, .link_nonfatal_event, .fbs_enable,
    .cmd_list_base, .rx_area_base, .rx_area_misaligned, .event_flags);
  pbis_event_src pbis_event_src_i (.clk_sys, .cold_presence_capable, .cold_presence_event,
    .tf_status_update, .tf_status, .host_bus_fatal_event, .host_bus_data_event,
    .link_fatal_event, .link_nonfatal_event);

  function automatic logic [11:0] at(input logic [6:0] o);
    return BASE + {5'h00, o};
  endfunction : at

  task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_sys);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    #1;
    chk({32'h0, reg_rdata}, {32'h0, exp}, what);
  endtask : rd

  task automatic t_reset;
    for (int i = 0; i < 5; i++) rd(at(7'(4 * i)), 32'h0000_0000, "reset read");
    chk(cmd_list_base | rx_area_base | {58'h0, event_flags}, 64'h0, "reset outputs");
    $display("t_reset done");
  endtask : t_reset

  task automatic t_bases;
    wr(at(PBIS_OFS_CLB_LO), 32'hFFFF_FFFF);
    rd(at(PBIS_OFS_CLB_LO), 32'hFFFF_FC00, "clb low");
    wr(at(PBIS_OFS_CLB_HI), 32'hA5A5_5A5A);
    rd(at(PBIS_OFS_CLB_HI), 32'hA5A5_5A5A, "clb high");
    chk(cmd_list_base, 64'hA5A5_5A5A_FFFF_FC00, "clb out");
    wr(at(PBIS_OFS_RXB_LO), 32'hFFFF_FFFF);
    rd(at(PBIS_OFS_RXB_LO), 32'hFFFF_FF00, "rxb low");
    wr(at(PBIS_OFS_RXB_HI), 32'h3C3C_C3C3);
    rd(at(PBIS_OFS_RXB_HI), 32'h3C3C_C3C3, "rxb high");
    chk(rx_area_base, 64'h3C3C_C3C3_FFFF_FF00, "rxb out");
    chk({63'h0, rx_area_misaligned}, 64'h0, "no fbs");
    @(posedge clk_sys);
    fbs_enable <= 1'b1;
    #1;
    chk({63'h0, rx_area_misaligned}, 64'h1, "fbs unaligned");
    wr(at(PBIS_OFS_RXB_LO), 32'h1234_5000);
    chk({63'h0, rx_area_misaligned}, 64'h0, "fbs aligned");
    wr(at(PBIS_OFS_RXB_LO), 32'h1234_5100);
    chk({63'h0, rx_area_misaligned}, 64'h1, "fbs bit 8");
    $display("t_bases done");
  endtask : t_bases

  task automatic t_events;
    for (int i = 0; i < 6; i++) begin
      pbis_event_src_i.fire(6'h01 << i, 1'b1, 8'h01);
      #1;
      chk({58'h0, event_flags}, 64'h1 << i, "flag set");
      rd(at(PBIS_OFS_STATUS), 32'h0400_0000 << i, "status read");
      wr(at(PBIS_OFS_STATUS), 32'h0000_0000);
      chk({58'h0, event_flags}, 64'h1 << i, "zero write");
      wr(at(PBIS_OFS_STATUS), 32'h0400_0000 << i);
      chk({58'h0, event_flags}, 64'h0, "one write");
    end
    pbis_event_src_i.fire(6'h20, 1'b0, 8'h01);
    #1;
    chk({58'h0, event_flags}, 64'h0, "cold not capable");
    pbis_event_src_i.fire(6'h10, 1'b1, 8'hFE);
    #1;
    chk({58'h0, event_flags}, 64'h0, "tf no error");
    pbis_event_src_i.fire(6'h3F, 1'b1, 8'h01);
    wr(at(PBIS_OFS_STATUS), 32'hA800_0000);
    rd(at(PBIS_OFS_STATUS), 32'h5400_0000, "partial clear");
    fork
      pbis_event_src_i.fire(6'h01, 1'b1, 8'h01);
      wr(at(PBIS_OFS_STATUS), 32'h0400_0000);
    join
    chk({58'h0, event_flags}, 64'h15, "set beats clear");
    wr(at(PBIS_OFS_STATUS), 32'hFC00_0000);
    chk({58'h0, event_flags}, 64'h0, "clear all");
    $display("t_events done");
  endtask : t_events

  task automatic t_map;
    wr(PBIS_PORT_BASE, 32'h0000_0000);
    rd(at(PBIS_OFS_CLB_LO), 32'hFFFF_FC00, "foreign port");
    @(posedge clk_sys);
    #1;
    chk({32'h0, reg_rdata}, 64'h0, "rdata one cycle");
    wr(at(7'h14), 32'hFFFF_FFFF);
    rd(at(7'h14), 32'h0000_0000, "unmapped");
    rd(PBIS_PORT_BASE, 32'h0000_0000, "port 0 read");
    $display("t_map done");
  endtask : t_map

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim

  // Whole sequence needs some 125 cycles; generous margin
  initial begin
    #20000;
    err_total++;
    $display("[FAIL] t=%0t watchdog", $time);
    end_sim();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_bases();
    t_events();
    t_map();
    end_sim();
  end
endmodule : tb_port_base_and_irq_status
`default_nettype wire
